// [port_read_defs.vh]
// constants for the block-input-with-decrement execution unit
// assumes a single 40 MHz clock and a core that supplies operands and takes results
// Summary of operation
// - each step reads the port named by the source pointer and writes that value to memory at the destination pointer.
// - the port address is always the full 16-bit source pointer value.
// - after each transfer the destination pointer drops by one for bytes or by two for words.
// - after each transfer the counter register drops by exactly one.
// - the single-step form sets overflow when the new counter is zero, clears it otherwise, and drives the zero flag low.
// - the repeat form loops until the new counter is zero and then ends with overflow set.
// - the repeat form takes 11 cycles plus 10 per element moved.
// - every variant runs only in the privileged state and traps otherwise.
// - the repeat form may be interrupted between steps and reports the instruction start address for resumption.
// - each interrupt accepted inside the repeat form adds seven cycles.
// - the source pointer is never changed by any variant.
// - in segmented mode the destination is a segment and offset pair and the step applies to the offset of that pair.
`ifndef PORT_READ_DEFS_VH
`define PORT_READ_DEFS_VH
`define BASE_CYCLES 8'h0B
`define STEP_CYCLES 8'h0A
`define IRQ_CYCLES 8'h07
`define SINGLE_CYCLES 8'h15
`define FIFO_DEPTH 4
`endif

// [word_fifo.v]
// small flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
module word_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW = 2
)(
	input wire mclk,
	input wire rst_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	// full and empty come from the occupancy count
	assign in_ready = (count != DEPTH); // compared at full width, no part-select of a parameter
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// pointers wrap; depth is a power of two
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule // word_fifo

// [block_input_decrement_exec.v]
// execution unit for block input with decrement, single-step and repeat, byte and word
// assumes the core hands over operands with start, and that ports and memory answer with acks
`include "port_read_defs.vh"
module block_input_decrement_exec (
	input wire mclk,
	input wire rst_n,
	input wire start,
	input wire repeat_mode,
	input wire word_mode,
	input wire privileged,
	input wire segmented,
	input wire [15:0] src_ptr,
	input wire [6:0] dst_seg,
	input wire [15:0] dst_off,
	input wire [15:0] count_in,
	input wire [15:0] instr_pc,
	input wire irq_req,
	output reg busy,
	output reg done,
	output reg trap,
	output reg irq_ack,
	output reg [15:0] resume_pc,
	output reg [15:0] dst_off_out,
	output reg [6:0] dst_seg_out,
	output reg [15:0] count_out,
	output reg flag_v,
	output reg flag_z,
	output reg [7:0] cycles,
	output reg port_rd,
	output reg [15:0] port_addr,
	output reg port_word,
	input wire [15:0] port_data,
	input wire port_ack,
	output reg mem_wr,
	output reg [22:0] mem_addr,
	output reg mem_word,
	output reg [15:0] mem_data,
	input wire mem_ack
);
	localparam S_IDLE = 3'd0;
	localparam S_PORT = 3'd1;
	localparam S_MEMQ = 3'd2;
	localparam S_NEXT = 3'd3;
	localparam S_DONE = 3'd4;

	reg [2:0] state;
	reg rep;
	reg wsel;
	reg seg;
	reg [15:0] sptr;
	reg [15:0] issued_off;
	wire [16:0] f_in_data;
	wire f_in_ready;
	wire [16:0] f_out_data;
	wire f_out_valid;
	wire [15:0] next_count;
	wire [15:0] next_off;

	// pointer step of one for bytes, two for words
	function [15:0] step_down;
		input [15:0] off;
		input w;
		begin
			step_down = off - (w ? 16'h0002 : 16'h0001);
		end
	endfunction

	assign next_count = count_out - 16'h0001;
	assign next_off = step_down(issued_off, wsel);
	// fifo carries port data plus byte/word flag; back-pressure stalls new port reads
	assign f_in_data = {wsel, wsel ? port_data : {8'h00, port_data[7:0]}};

	word_fifo #(
		.WIDTH(17),
		.DEPTH(`FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_data(f_in_data),
		.in_valid(port_rd & port_ack),
		.in_ready(f_in_ready),
		.out_data(f_out_data),
		.out_valid(f_out_valid),
		.out_ready(~mem_wr & (state == S_MEMQ))
	);

	// main sequencer: one element per pass, port read then memory write
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			trap <= 1'b0;
			irq_ack <= 1'b0;
			resume_pc <= 16'h0000;
			dst_off_out <= 16'h0000;
			dst_seg_out <= 7'h00;
			count_out <= 16'h0000;
			flag_v <= 1'b0;
			flag_z <= 1'b0;
			cycles <= 8'h00;
			port_rd <= 1'b0;
			port_addr <= 16'h0000;
			port_word <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= 23'h00_0000;
			mem_word <= 1'b0;
			mem_data <= 16'h0000;
			rep <= 1'b0;
			wsel <= 1'b0;
			seg <= 1'b0;
			sptr <= 16'h0000;
			issued_off <= 16'h0000;
		end
		else
		begin
			done <= 1'b0;
			trap <= 1'b0;
			irq_ack <= 1'b0;
			// memory write completes on its ack
			if (mem_wr & mem_ack)
				mem_wr <= 1'b0;
			case (state)
				S_IDLE:
				begin
					if (start)
					begin
						if (!privileged)
							trap <= 1'b1;
						else
						begin
							busy <= 1'b1;
							rep <= repeat_mode;
							wsel <= word_mode;
							seg <= segmented;
							sptr <= src_ptr; // source pointer held, never written back
							issued_off <= dst_off;
							dst_off_out <= dst_off;
							dst_seg_out <= segmented ? dst_seg : 7'h00;
							count_out <= count_in; // software keeps count in range
							resume_pc <= instr_pc;
							cycles <= repeat_mode ? `BASE_CYCLES : `SINGLE_CYCLES;
							port_rd <= 1'b1;
							port_addr <= src_ptr; // full 16-bit port address
							port_word <= word_mode;
							state <= S_PORT;
						end
					end
				end
				S_PORT:
				begin
					// port read handshake feeds the fifo
					if (port_ack & f_in_ready)
					begin
						port_rd <= 1'b0;
						state <= S_MEMQ;
					end
				end
				S_MEMQ:
				begin
					// drain one element to memory at the destination pointer
					if (f_out_valid & ~mem_wr)
					begin
						mem_wr <= 1'b1;
						mem_addr <= {(seg ? dst_seg_out : 7'h00), issued_off};
						mem_word <= f_out_data[16];
						mem_data <= f_out_data[15:0];
						state <= S_NEXT;
					end
				end
				S_NEXT:
				begin
					if (mem_wr & mem_ack)
					begin
						issued_off <= next_off; // offset only, segment untouched
						dst_off_out <= next_off;
						count_out <= next_count;
						flag_z <= 1'b0; // zero flag left undefined, driven low
						if (!rep)
						begin
							flag_v <= (next_count == 16'h0000);
							state <= S_DONE;
						end
						else
						begin
							cycles <= cycles + `STEP_CYCLES;
							if (next_count == 16'h0000)
							begin
								flag_v <= 1'b1;
								state <= S_DONE;
							end
							else if (irq_req)
							begin
								// yield between steps; core restarts at resume_pc
								irq_ack <= 1'b1;
								cycles <= cycles + `STEP_CYCLES + `IRQ_CYCLES;
								busy <= 1'b0;
								state <= S_IDLE;
							end
							else
							begin
								port_rd <= 1'b1;
								port_addr <= sptr;
								state <= S_PORT;
							end
						end
					end
				end
				S_DONE:
				begin
					busy <= 1'b0;
					done <= 1'b1;
					state <= S_IDLE;
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule // block_input_decrement_exec

// [mem_port_model.sv]
// far side: i/o ports and memory answering the unit's strobes
// assumes strobes are held until acked
module mem_port_model (
	input logic mclk,
	input logic rst_n,
	input logic slow,
	input logic port_rd,
	input logic [15:0] port_addr,
	output logic port_ack,
	output logic [15:0] port_data,
	output logic [15:0] last,
	input logic mem_wr,
	output logic mem_ack
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] wt;
	logic [7:0] seq;
	// data toggles unless handed over, so a late capture shows up
	always @(posedge mclk)
	begin
		port_ack <= 0;
		mem_ack <= 0;
		port_data <= rst_n ? ~port_data : 16'h5a3c;
		wt <= (port_rd | mem_wr) && !port_ack && !mem_ack ? wt + 2'h1 : 2'h0;
		if (port_rd && !port_ack && wt >= {slow, 1'b0})
		begin
			port_ack <= 1;
			seq <= seq + 8'h01;
			port_data <= {port_addr[7:0] ^ seq, seq + 8'h3b};
			last <= {port_addr[7:0] ^ seq, seq + 8'h3b};
		end
		if (mem_wr && !mem_ack && wt >= {slow, 1'b0})
			mem_ack <= 1;
		// known start so port data can never be unknown
		if (!rst_n)
		begin
			seq <= 8'h00;
			wt <= 2'h0;
		end
	end
endmodule // mem_port_model

// [block_input_decrement_exec_monitor.sv]
// assertions on the unit's ports
// assumes one clock and synchronous active-low reset
module block_input_decrement_exec_monitor (
	input logic mclk,
	input logic rst_n,
	input logic start,
	input logic privileged,
	input logic busy,
	input logic done,
	input logic trap,
	input logic port_rd,
	input logic port_ack,
	input logic [15:0] port_addr,
	input logic [15:0] src_ptr,
	input logic mem_wr,
	input logic mem_ack,
	input logic mem_word,
	input logic [15:0] mem_data,
	input logic flag_v,
	input logic [15:0] count_out
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence read_taken;
		port_rd && port_ack;
	endsequence
	sequence write_next;
		!port_rd ##1 mem_wr;
	endsequence
	AST_ADDR: assert property (port_rd |-> port_addr == src_ptr)
		else $error("port address not source pointer");
	AST_TRAP: assert property (start && !busy && !privileged |=> trap && !busy)
		else $error("unprivileged start not trapped");
	AST_GO: assert property (start && !busy && privileged |=> busy && port_rd)
		else $error("privileged start did not read");
	AST_ORDER: assert property (read_taken |=> write_next)
		else $error("write did not follow read");
	AST_HOLD: assert property (port_rd && !port_ack |=> port_rd)
		else $error("read dropped before ack");
	AST_DONE: assert property (done |-> $past(mem_ack, 2) && !busy)
		else $error("done not after final write");
	AST_FLAG: assert property (done |-> flag_v == (count_out == 16'h0000))
		else $error("overflow flag wrong");
	AST_BYTE: assert property (mem_wr && !mem_word |-> mem_data[15:8] == 8'h00)
		else $error("byte write upper byte set");
	AST_PULSE: assert property (trap |=> !trap)
		else $error("trap longer than one cycle");
endmodule // block_input_decrement_exec_monitor

// [tb_block_input_decrement_exec.sv]
// bench: random single and repeat ops, traps and interrupts
// assumes mem_port_model answers the strobes
module tb_block_input_decrement_exec;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, rst_n = 0, start = 0, repeat_mode = 0, word_mode = 0, privileged = 0;
	logic segmented = 0, irq_req = 0, slow = 0;
	logic [15:0] src_ptr = 0, dst_off = 0, count_in = 0, instr_pc = 0, e_off, e_cnt;
	logic [6:0] dst_seg = 0;
	logic [31:0] rs = 57, r;
	wire busy, done, trap, irq_ack, port_rd, port_word, port_ack, mem_wr, mem_word, mem_ack, flag_v;
	wire flag_z;
	wire [6:0] dst_seg_out;
	wire [15:0] resume_pc, dst_off_out, count_out, port_addr, port_data, mem_data, last;
	wire [7:0] cycles;
	wire [22:0] mem_addr;
	int bad_count = 0, n_tests = 0;
	always #12.5 mclk = ~mclk;
	block_input_decrement_exec uut (.mclk, .rst_n, .start, .repeat_mode, .word_mode, .privileged,
		.segmented, .src_ptr, .dst_seg, .dst_off, .count_in, .instr_pc, .irq_req, .busy, .done,
		.trap, .irq_ack, .resume_pc, .dst_off_out, .dst_seg_out, .count_out, .flag_v,
		.flag_z, .cycles, .port_rd, .port_addr, .port_word, .port_data, .port_ack, .mem_wr,
		.mem_addr, .mem_word, .mem_data, .mem_ack);
	mem_port_model far (.mclk, .rst_n, .slow, .port_rd, .port_addr, .port_ack, .port_data, .last,
		.mem_wr, .mem_ack);
	function logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task chk(input logic [22:0] g, e);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %0t got %h want %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// track every accepted write against the expected place and value
	always @(posedge mclk)
	begin
		if (port_rd && port_ack)
			chk(port_word, word_mode);
		if (mem_wr && mem_ack)
		begin
			chk(mem_addr, {segmented ? dst_seg : 7'h00, e_off});
			chk(mem_data, word_mode ? last : {8'h00, last[7:0]});
			chk(mem_word, word_mode);
			e_off = e_off - (word_mode ? 16'h0002 : 16'h0001);
			e_cnt = e_cnt - 16'h0001;
		end
	end
	task run(input logic rp, wd, p, input logic [15:0] c, input logic iq);
		int k;
		logic [15:0] o0;
		logic [15:0] n;
		logic [15:0] cs;
		@(posedge mclk);
		o0 = dst_off;
		e_off = dst_off;
		e_cnt = c;
		cs = c;
		n = !p ? 16'h0000 : rp ? c : 16'h0001;
		repeat_mode <= rp;
		word_mode <= wd;
		privileged <= p;
		count_in <= c;
		irq_req <= iq;
		start <= 1;
		k = 0;
		// restart with the updated operands whenever an interrupt is taken
		do
		begin
			@(posedge mclk);
			start <= 0;
			if (irq_ack)
			begin
				chk(resume_pc, instr_pc);
				chk(cycles, 11 + 10 * (cs - count_out) + 7);
				cs = count_out;
				irq_req <= 0;
				count_in <= count_out;
				dst_off <= dst_off_out;
				start <= 1;
			end
			k++;
		end while (!done && !trap && k < 3000);
		// a hung operation counts as a mismatch
		if (k >= 3000)
		begin
			bad_count++;
			$display("Error %0t operation never finished", $time);
		end
		chk(trap, !p);
		chk(e_cnt, 16'(c - n));
		if (p)
		begin
			chk(count_out, 16'(c - n));
			chk(dst_off_out, 16'(o0 - (wd ? 2 * n : n)));
			chk(dst_seg_out, segmented ? dst_seg : 7'h00);
			chk(flag_v, c == n);
			chk(flag_z, 1'b0);
			chk(cycles, rp ? 11 + 10 * cs : 21);
		end
		$display("op end rep %0d word %0d count %0d", rp, wd, c);
	endtask
	// watchdog sized well above the longest expected run
	initial
	begin
		#500000;
		bad_count++;
		close_out;
	end
	// corners first, then random ops with small counts
	initial
	begin
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		run(0, 0, 0, 16'h0005, 0);
		run(0, 1, 1, 16'h0001, 0);
		run(0, 0, 1, 16'h0000, 0);
		run(1, 1, 1, 16'h0003, 1); // interrupt taken between steps
		for (int i = 0; i < 14; i++)
		begin
			r = xs();
			src_ptr <= r[15:0];
			dst_off <= r[31:16];
			dst_seg <= r[6:0];
			segmented <= r[7];
			slow <= r[8];
			instr_pc <= r[23:8];
			run(r[9], r[10], 1, 16'h0001 + r[13:11], r[9] & r[14]);
		end
		close_out;
	end
endmodule // tb_block_input_decrement_exec
bind block_input_decrement_exec block_input_decrement_exec_monitor mon (.mclk, .rst_n, .start,
	.privileged, .busy, .done, .trap, .port_rd, .port_ack, .port_addr, .src_ptr, .mem_wr,
	.mem_ack, .mem_word, .mem_data, .flag_v, .count_out);
